// ---- logic/nlm_defs.svh ----
// Constants of the node liveness monitor: offsets, fields, timing counts.
//----------------------------------------------------------------------
// Overview of operation
// - Module count at index zero, entries 1..74
// - Each entry a read-only 16-bit type code
// - Fault byte bits 0,1,2,4,7; others zero
// - Master sends guard requests every guard interval
// - Node answers guard; silence gives timeout state
// - Failed after lifetime-multiplier missed guard attempts
// - Heartbeat supervision armed by first heartbeat
// - Zero heartbeat timeout disables the entry
// - Heartbeat timeout counted in millisecond units
// - Consumer timeout should exceed producer period
// - Entry: 31..24 reserved, 23..16 node, 15..0 time
// - Heartbeat uses data frames only, never remote
//----------------------------------------------------------------------
`ifndef NLM_DEFS_SVH
`define NLM_DEFS_SVH

// Object offsets (register index) of the object dictionary
`define NLM_OFS_FAULT        16'h1001
`define NLM_OFS_GUARD_INT    16'h100c
`define NLM_OFS_GUARD_MULT   16'h100d
`define NLM_OFS_HB_ENTRY     16'h1016
`define NLM_OFS_MOD_LIST     16'h1027
// Controller registers of our own
`define NLM_OFS_IRQ_STATUS   16'h2000
`define NLM_OFS_IRQ_CLEAR    16'h2001
`define NLM_OFS_IRQ_ENABLE   16'h2002
`define NLM_OFS_NODE_STATE   16'h2003

// Fault byte bits
`define NLM_FB_GENERIC       0
`define NLM_FB_CURRENT       1
`define NLM_FB_VOLTAGE       2
`define NLM_FB_COMM          4
`define NLM_FB_VENDOR        7
`define NLM_FB_MASK          8'h97

// Module list limits
`define NLM_MOD_MAX          7'h4a
// Neutral type code of an empty slot, arbitrary value
`define NLM_MOD_NONE         16'h0000

// Heartbeat entry fields
`define NLM_HB_NODE_MSB      23
`define NLM_HB_NODE_LSB      16
`define NLM_HB_TIME_MSB      15
`define NLM_HB_TIME_LSB      0

// Timing: millisecond tick from 20 MHz clock
`define NLM_CLK_HZ           20000000
`define NLM_TICK_MS          1
`define NLM_TICK_CYC         ((`NLM_CLK_HZ / 1000) * `NLM_TICK_MS)

// Interrupt status bits
`define NLM_IRQ_HB_FAIL      0
`define NLM_IRQ_GUARD_TO     1
`define NLM_IRQ_GUARD_FAIL   2
`define NLM_IRQ_GUARD_ANS    3

`endif

// ---- logic/nlm_pkg.sv ----
// Types of the monitoring master of the node liveness monitor.
package nlm_pkg;

	//------------------------------------------------------------------
	// Guard master states
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		NLM_G_IDLE,
		NLM_G_WAIT,
		NLM_G_FAILED
	} nlm_gstate_t;

endpackage

// ---- logic/nlm_link_if.sv ----
// Link between the monitored station and the monitoring master.
`timescale 1ns/1ps
interface nlm_link_if (
	input wire logic mclk_i,
	input wire logic nrst_i
);
	logic       guard_req;   // Guard request frame, one-cycle pulse
	logic       guard_ans;   // Guard answer frame on guard identifier
	logic       hb_frame;    // Heartbeat data frame, one-cycle pulse
	logic [7:0] hb_node;     // Producer node of the heartbeat

	modport station (
		input  guard_req,
		output guard_ans,
		input  hb_frame,
		input  hb_node
	);

	modport master (
		output guard_req,
		input  guard_ans,
		output hb_frame,
		output hb_node
	);
endinterface

// ---- logic/nlm_master.sv ----
// Monitoring master: guard requests, guard timeout and node failure.
`timescale 1ns/1ps
`include "nlm_defs.svh"
module nlm_master (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	nlm_link_if.master       link,
	input  wire logic [15:0] guard_interval_i,
	input  wire logic [7:0]  guard_retry_multiplier_i,
	input  wire logic        hb_send_i,
	input  wire logic [7:0]  hb_node_i,
	output logic             node_timeout_o,
	output logic             node_failed_o
);
	typedef struct packed {
		nlm_pkg::nlm_gstate_t st;
		logic [15:0]          tick;
		logic [15:0]          ms;
		logic [7:0]           misses;
		logic                 answered;
		logic                 req;
		logic                 timeout;
		logic                 failed;
		logic                 hb;
		logic [7:0]           hbn;
	} nlm_mst_t;

	nlm_mst_t r;
	nlm_mst_t next_r;

	//------------------------------------------------------------------
	// Guard sequencer
	//------------------------------------------------------------------
	// Guarding starts only with interval and multiplier nonzero; a zero interval stops it
	always_comb begin
		next_r     = r;
		next_r.req = 1'b0;
		next_r.hb  = hb_send_i;
		next_r.hbn = hb_node_i;
		if (link.guard_ans) begin
			next_r.answered = 1'b1;
		end
		next_r.tick = (r.tick == 16'(`NLM_TICK_CYC - 1)) ? 16'h0000 : r.tick + 16'h0001;
		case (r.st)
			nlm_pkg::NLM_G_IDLE: begin
				if (guard_interval_i != 16'h0000 && guard_retry_multiplier_i != 8'h00) begin
					next_r.st       = nlm_pkg::NLM_G_WAIT;
					next_r.req      = 1'b1;
					next_r.ms       = 16'h0000;
					next_r.answered = 1'b0;
					// Restart the divider so the first interval is a full one
					next_r.tick     = 16'h0000;
				end
			end
			nlm_pkg::NLM_G_WAIT: begin
				if (guard_interval_i == 16'h0000) begin
					next_r.st = nlm_pkg::NLM_G_IDLE;
				end else if (r.tick == 16'(`NLM_TICK_CYC - 1)) begin
					next_r.ms = r.ms + 16'h0001;
					if (r.ms + 16'h0001 >= guard_interval_i) begin
						next_r.ms       = 16'h0000;
						next_r.req      = 1'b1;
						next_r.answered = 1'b0;
						if (r.answered || link.guard_ans) begin
							next_r.misses  = 8'h00;
							next_r.timeout = 1'b0;
						end else begin
							next_r.timeout = 1'b1;
							next_r.misses  = r.misses + 8'h01;
							if (r.misses + 8'h01 >= guard_retry_multiplier_i) begin
								next_r.failed = 1'b1;
								next_r.st     = nlm_pkg::NLM_G_FAILED;
							end
						end
					end
				end
			end
			nlm_pkg::NLM_G_FAILED: begin
				// Stays failed until reset; recovery is a management decision
				next_r.st = nlm_pkg::NLM_G_FAILED;
			end
			default: begin
				next_r.st = nlm_pkg::NLM_G_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign link.guard_req = r.req;
	assign link.hb_frame  = r.hb;
	assign link.hb_node   = r.hbn;
	assign node_timeout_o = r.timeout;
	assign node_failed_o  = r.failed;
endmodule

// ---- logic/nlm_station.sv ----
// Monitored station: object registers, guard answer, heartbeat consumer.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "nlm_defs.svh"
module nlm_station (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	nlm_link_if.station      link,
	input  wire logic [15:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	input  wire logic [6:0]  module_count_i,
	input  wire logic [15:0] module_code_i [74],
	input  wire logic [7:0]  fault_src_i,
	output logic             irq_o,
	output logic             hb_failed_o
);
	// Three jobs share one state word: the object registers on the
	// software port, the answer to guard requests on the link, and the
	// heartbeat consumer. Everything moves on mclk_i; the millisecond
	// time base is a free-running divider, so a heartbeat timeout is
	// resolved to the millisecond and may come up to one millisecond
	// early. Users who need margin should set one extra millisecond.
	typedef struct packed {
		logic [15:0] guard_interval;
		logic [7:0]  guard_retry_multiplier;
		logic [31:0] hb_entry;
		logic        armed;
		logic        failed;
		logic [15:0] tick;
		logic [15:0] ms;
		logic [3:0]  status;
		logic [3:0]  enable;
		logic        ans;
		logic [7:0]  fault_meta;
		logic [7:0]  fault_sync;
		logic [31:0] rdata;
	} nlm_sta_t;

	nlm_sta_t r;
	nlm_sta_t next_r;
	logic [7:0]  fault_byte;
	logic [15:0] hb_time;
	logic [7:0]  hb_node;
	logic [3:0]  ev;
	logic        hb_match;

	// Fault byte keeps bits 3, 5 and 6 at zero; only the second stage is read
	assign fault_byte = r.fault_sync & `NLM_FB_MASK;
	// Reserved entry bits are never looked at
	assign hb_time  = r.hb_entry[`NLM_HB_TIME_MSB:`NLM_HB_TIME_LSB];
	assign hb_node  = r.hb_entry[`NLM_HB_NODE_MSB:`NLM_HB_NODE_LSB];
	// Only heartbeat data frames count, never guard requests
	assign hb_match = link.hb_frame && link.hb_node == hb_node;

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	// Last cycle of a millisecond; the divider and the timeout share it
	function automatic logic tick_last(input logic [15:0] t);
		tick_last = (t == 16'(`NLM_TICK_CYC - 1));
	endfunction

	// Millisecond divider: one enable per 1 ms, no second clock
	function automatic logic [15:0] tick_next(input logic [15:0] t);
		tick_next = tick_last(t) ? 16'h0000 : t + 16'h0001;
	endfunction

	// True when the index falls in the module list window
	function automatic logic in_mod_list(input logic [15:0] a);
		in_mod_list = (a >= `NLM_OFS_MOD_LIST) &&
			(a <= `NLM_OFS_MOD_LIST + 16'(`NLM_MOD_MAX));
	endfunction

	// One list entry: count at slot zero, type code while the slot is
	// populated, zero past the count so empty slots read as such
	function automatic logic [31:0] mod_entry(
		input logic [15:0] a,
		input logic [6:0]  count,
		input logic [15:0] codes [74]
	);
		logic [15:0] module_slot_index;
		module_slot_index = a - `NLM_OFS_MOD_LIST;
		mod_entry         = 32'h0000_0000;
		if (module_slot_index == 16'h0000) begin
			mod_entry = {25'h0, count};
		end else if (module_slot_index <= {9'h0, count}) begin
			mod_entry = {16'h0000, codes[7'(module_slot_index - 16'h0001)]};
		end
	endfunction

	// Register file read; unmapped indexes read as zero
	function automatic logic [31:0] reg_word(
		input logic [15:0] a,
		input nlm_sta_t    s,
		input logic [7:0]  fb
	);
		case (a)
			`NLM_OFS_FAULT:      reg_word = {24'h0, fb};
			`NLM_OFS_GUARD_INT:  reg_word = {16'h0, s.guard_interval};
			`NLM_OFS_GUARD_MULT: reg_word = {24'h0, s.guard_retry_multiplier};
			`NLM_OFS_HB_ENTRY:   reg_word = s.hb_entry;
			`NLM_OFS_IRQ_STATUS: reg_word = {28'h0, s.status};
			`NLM_OFS_IRQ_ENABLE: reg_word = {28'h0, s.enable};
			`NLM_OFS_NODE_STATE: reg_word = {30'h0, s.failed, s.armed};
			default:             reg_word = 32'h0000_0000;
		endcase
	endfunction

	// Register file write; read-only and unmapped indexes ignore the strobe
	function automatic nlm_sta_t reg_write(
		input nlm_sta_t    s,
		input logic [15:0] a,
		input logic [31:0] d
	);
		reg_write = s;
		case (a)
			`NLM_OFS_GUARD_INT: begin
				reg_write.guard_interval = d[15:0];
			end
			`NLM_OFS_GUARD_MULT: begin
				reg_write.guard_retry_multiplier = d[7:0];
			end
			`NLM_OFS_HB_ENTRY: begin
				// New entry starts unarmed; the next frame of its node arms it
				reg_write.hb_entry = {8'h00, d[23:0]};
				reg_write.armed    = 1'b0;
				reg_write.failed   = 1'b0;
				reg_write.ms       = 16'h0000;
			end
			`NLM_OFS_IRQ_CLEAR: begin
				// Write one to clear; the event merge that follows may set again
				reg_write.status = s.status & ~d[3:0];
			end
			`NLM_OFS_IRQ_ENABLE: begin
				reg_write.enable = d[3:0];
			end
			default: begin
			end
		endcase
	endfunction

	//------------------------------------------------------------------
	// Register access, guard answer, heartbeat supervision
	//------------------------------------------------------------------
	always_comb begin
		next_r       = r;
		next_r.rdata = 32'h0000_0000;
		next_r.ans   = link.guard_req;
		ev           = 4'h0;
		// Fault lines come from the I/O modules, off this clock: two stages
		next_r.fault_meta = fault_src_i;
		next_r.fault_sync = r.fault_meta;
		// Millisecond tick
		next_r.tick = tick_next(r.tick);
		// Heartbeat consumer: zero time disables, a matching frame arms and restarts
		if (hb_time == 16'h0000) begin
			next_r.armed = 1'b0;
			next_r.ms    = 16'h0000;
		end else if (hb_match) begin
			next_r.armed = 1'b1;
			next_r.ms    = 16'h0000;
		end else if (r.armed && !r.failed && tick_last(r.tick)) begin
			next_r.ms = r.ms + 16'h0001;
			if (r.ms + 16'h0001 >= hb_time) begin
				next_r.failed            = 1'b1;
				ev[`NLM_IRQ_HB_FAIL]     = 1'b1;
			end
		end
		if (hb_match) begin
			next_r.failed = 1'b0;
		end
		ev[`NLM_IRQ_GUARD_ANS] = link.guard_req;
		// Writes land before the event merge so a set in the same cycle wins
		if (wr_i) begin
			next_r = reg_write(next_r, addr_i, wdata_i);
		end
		// Set wins over clear
		next_r.status = next_r.status | ev;
		// Reads; the word stands for the one cycle after the strobe
		if (rd_i) begin
			if (in_mod_list(addr_i)) begin
				next_r.rdata = mod_entry(addr_i, module_count_i, module_code_i);
			end else begin
				next_r.rdata = reg_word(addr_i, r, fault_byte);
			end
		end
	end

	//------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	// irq_o is a level, high while any enabled status bit is set
	assign link.guard_ans = r.ans;
	assign rdata_o        = r.rdata;
	assign irq_o          = |(r.status & r.enable);
	assign hb_failed_o    = r.failed;
endmodule

// ---- verif/nlm_link_assertions.sv ----
// Checker of the guard link between master and station.
`timescale 1ns/1ps
module nlm_link_assertions (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       guard_req,
	input wire logic       guard_ans,
	input wire logic       hb_frame,
	input wire logic [7:0] hb_node
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	//----
	// Gap counter
	//----
	// Cycles since the last guard request; saturates so long idles never wrap
	logic [15:0] gap;
	logic        seen;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap  <= 16'h0000;
			seen <= 1'h0;
		end else begin
			gap  <= guard_req ? 16'h0000 : gap + {15'h0000, ~&gap};
			seen <= seen | guard_req;
		end
	end
	a_guard_answered: assert property (guard_req |=> guard_ans)
		else $error("guard request unanswered");
	a_answer_caused: assert property (guard_ans |-> $past(guard_req))
		else $error("guard answer without request");
	// Bench sets a 1 ms interval, so requests sit 20000 cycles apart
	a_guard_spacing: assert property (guard_req && seen |-> gap >= 16'h4e1f)
		else $error("guard requests too close");
	a_answer_single: assert property (guard_ans |=> !guard_ans)
		else $error("guard answer longer than a pulse");
	a_req_single: assert property (guard_req |=> !guard_req)
		else $error("guard request longer than a pulse");
	// A full interval with no request means the master stopped guarding
	a_guard_period: assert property (seen && gap == 16'h4e1f |-> guard_req)
		else $error("guard request overdue");
endmodule

// ---- verif/tb_top.sv ----
// Testbench of the node liveness monitor, both ends joined by the link.
`timescale 1ns/1ps
module tb_top;
	logic        mclk_i = 1'h0;
	logic        nrst_i = 1'h0;
	logic [15:0] addr_i = 16'h0000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i = 1'h0;
	logic        rd_i = 1'h0;
	logic [7:0]  fault_src_i = 8'h00;
	logic        hb_send = 1'h0;
	logic [7:0]  hb_nd = 8'h00;
	logic [15:0] codes [74];
	logic [31:0] rdata_o;
	logic        irq_o;
	logic        hb_failed_o;
	logic        tmo_o;
	logic        fail_o;
	int          bad_count = 0;
	int          check_count = 0;

	always #25 mclk_i = ~mclk_i;
	// Slot k carries type code 0x0100 + k - 1
	initial for (int k = 0; k < 74; k++) codes[k] = 16'h0100 + 16'(k);

	nlm_link_if nlm_link_if_inst (.mclk_i(mclk_i), .nrst_i(nrst_i));
	nlm_link_assertions nlm_link_assertions_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.guard_req(nlm_link_if_inst.guard_req), .guard_ans(nlm_link_if_inst.guard_ans),
		.hb_frame(nlm_link_if_inst.hb_frame), .hb_node(nlm_link_if_inst.hb_node));
	// Guard runs all along at 1 ms with two tries
	nlm_master nlm_master_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(nlm_link_if_inst),
		.guard_interval_i(16'h0001), .guard_retry_multiplier_i(8'h02),
		.hb_send_i(hb_send), .hb_node_i(hb_nd), .node_timeout_o(tmo_o),
		.node_failed_o(fail_o));
	nlm_station nlm_station_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(nlm_link_if_inst),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.module_count_i(7'h03), .module_code_i(codes), .fault_src_i(fault_src_i),
		.irq_o(irq_o), .hb_failed_o(hb_failed_o));

	//----
	// Shared tasks
	//----
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		check_count++;
		if (seen !== e) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, e, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i    <= 1'h1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i    <= 1'h0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		rd_i   <= 1'h1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i   <= 1'h0;
		#1;
		chk($sformatf("reg %h", a), rdata_o, e);
	endtask
	task automatic hb(input logic [7:0] n);
		@(posedge mclk_i);
		hb_send <= 1'h1;
		hb_nd   <= n;
		@(posedge mclk_i);
		hb_send <= 1'h0;
		repeat (2) @(posedge mclk_i);
	endtask

	//----
	// Scenarios
	//----
	// Count, codes, empty slot past the count, write to a read-only entry
	task automatic t_list();
		rc(16'h1027, 32'h0000_0003);
		for (int k = 1; k < 5; k++) rc(16'h1027 + 16'(k), k < 4 ? 32'h0000_00ff + k : 0);
		wr(16'h1028, 32'h0000_ffff);
		rc(16'h1028, 32'h0000_0100);
		rc(16'h3000, 32'h0000_0000);
	endtask
	// Unused fault bits must read zero whatever the sources say
	task automatic t_fault();
		@(posedge mclk_i);
		fault_src_i <= 8'hff;
		repeat (2) @(posedge mclk_i);
		rc(16'h1001, 32'h0000_0097);
		@(posedge mclk_i);
		fault_src_i <= 8'h68;
		repeat (2) @(posedge mclk_i);
		rc(16'h1001, 32'h0000_0000);
	endtask
	// Supervision: not armed before a frame, ms timing, masked then enabled irq
	task automatic t_hb();
		// Two ms timeout, shorter than the wait before node 5 sends its next frame below
		wr(16'h1016, 32'hff05_0002);
		rc(16'h1016, 32'h0005_0002);
		repeat (25000) @(posedge mclk_i);
		#1;
		chk("unarmed", 32'(hb_failed_o), 0);
		hb(8'h06);
		rc(16'h2003, 32'h0000_0000);
		hb(8'h05);
		rc(16'h2003, 32'h0000_0001);
		repeat (19000) @(posedge mclk_i);
		#1;
		chk("early", 32'(hb_failed_o), 0);
		repeat (22000) @(posedge mclk_i);
		#1;
		chk("late", 32'(hb_failed_o), 1);
		chk("masked", 32'(irq_o), 0);
		wr(16'h2002, 32'h0000_0001);
		chk("irq", 32'(irq_o), 1);
		hb(8'h05);
		wr(16'h2001, 32'h0000_000f);
		chk("cleared", 32'(hb_failed_o), 0);
		chk("irq off", 32'(irq_o), 0);
		wr(16'h1016, 32'h0005_0000);
		hb(8'h05);
		rc(16'h2003, 32'h0000_0000);
		chk("timeout", 32'(tmo_o), 0);
		chk("failed", 32'(fail_o), 0);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Run takes about 70000 cycles; the watchdog allows 100000
	initial begin
		repeat (100000) @(posedge mclk_i);
		bad_count++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'h1;
		t_list();
		t_fault();
		t_hb();
		close_out();
	end
endmodule
